// file: rtl/pix_out_pkg.sv
// Constants shared by the pixel output stage and its two-entry buffer.
// Assumes a single 125 MHz system clock domain.
package pix_out_pkg;
  localparam int PIXEL_W  = 24;
  localparam int WORD_W   = 2 * PIXEL_W + 6;   // Even, odd, qualifier, two syncs, three controls
  localparam int POS_ODD  = PIXEL_W;
  localparam int POS_QUAL = 2 * PIXEL_W;
  localparam int POS_HS   = POS_QUAL + 1;
  localparam int POS_VS   = POS_QUAL + 2;
  localparam int POS_CTL  = POS_QUAL + 3;
  localparam logic [PIXEL_W-1:0] PIXEL_ZERO = 24'h000000;
  localparam logic [1:0]         SYNC_STAGES = 2'h2;
endpackage : pix_out_pkg

// file: rtl/pix_skid_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module pix_skid_buf
  import pix_out_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [WORD_W-1:0] in_data,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output logic [WORD_W-1:0]      out_data,
  output logic                   out_valid,
  input  wire logic              out_ready
);
  logic [WORD_W-1:0] mem_reg [2];
  logic [WORD_W-1:0] mem_next [2];
  logic              wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [1:0]        cnt_reg, cnt_next;
  logic              push, pop;
  logic              room_reg, room_next;

  ////////////////////////////////////////////////////////////////////////
  // Pointer and count update; push only when not full
  always_comb begin
    push      = in_valid && room_reg;
    pop       = out_ready && (cnt_reg != 2'h0);
    mem_next  = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (push) begin
      mem_next[wptr_reg] = in_data;
      wptr_next = ~wptr_reg;
    end
    if (pop) begin
      rptr_next = ~rptr_reg;
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    room_next = (cnt_next != 2'h2);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wptr_reg   <= 1'b0;
      rptr_reg   <= 1'b0;
      cnt_reg    <= 2'h0;
      room_reg   <= 1'b0;
    end else begin
      mem_reg  <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg  <= cnt_next;
      room_reg <= room_next;
    end
  end

  // Ready is registered so the top-level ready comes from a flop; low in reset
  assign in_ready  = room_reg;
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rptr_reg];
endmodule : pix_skid_buf
`default_nettype wire

// file: rtl/pix_out_stage.sv
// Parallel pixel output stage: drives even/odd pixel buses, pixel clock,
// qualifier, syncs and three controls, with output power-down.
// Assumes the link clock arrives unsynchronised; the pixel source is on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module pix_out_stage
  import pix_out_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               link_clock,
  input  wire logic [PIXEL_W-1:0] src_even_pixel,
  input  wire logic [PIXEL_W-1:0] src_odd_pixel,
  input  wire logic               src_active,
  input  wire logic               src_hsync,
  input  wire logic               src_vsync,
  input  wire logic [2:0]         src_control,
  input  wire logic               src_valid,
  output logic                    src_ready,
  input  wire logic               full_power_down_n,
  input  wire logic               output_power_down_n,
  input  wire logic               clock_polarity_select,
  input  wire logic               pixels_per_clock_select,
  input  wire logic               staggered_output_select_n,
  output logic [PIXEL_W-1:0]      even_pixel_out,
  output logic [PIXEL_W-1:0]      odd_pixel_out,
  output logic                    pixel_out_clock,
  output logic                    active_video_flag,
  output logic                    hsync_out,
  output logic                    vsync_out,
  output logic                    aux_control_out_1,
  output logic                    aux_control_out_2,
  output logic                    aux_control_out_3,
  output logic                    main_out_en,
  output logic                    aux1_out_en
);
  typedef enum logic [1:0] {ST_IDLE, ST_RISE, ST_FALL} edge_t;

  logic [WORD_W-1:0] buf_data;
  logic              buf_valid, buf_ready;
  logic              pop_word;

  // Field pickers for a buffered word; logic and checks share them
  function automatic logic [PIXEL_W-1:0] even_field(input logic [WORD_W-1:0] w);
    return w[POS_ODD-1:0];
  endfunction : even_field

  function automatic logic [PIXEL_W-1:0] odd_field(input logic [WORD_W-1:0] w);
    return w[POS_QUAL-1:POS_ODD];
  endfunction : odd_field

  ////////////////////////////////////////////////////////////////////////
  // Buffer between source and the output timing
  pix_skid_buf u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   ({src_control, src_vsync, src_hsync, src_active, src_odd_pixel, src_even_pixel}),
    .in_valid  (src_valid),
    .in_ready  (buf_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (pop_word)
  );
  assign src_ready = buf_ready;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers: link clock and the static pins
  logic [5:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
  logic       lclk_last_reg, lclk_last_next;
  always_comb begin
    sync1_next     = {link_clock, full_power_down_n, output_power_down_n,
                      clock_polarity_select, pixels_per_clock_select, staggered_output_select_n};
    sync2_next     = sync1_reg;
    lclk_last_next = sync2_reg[5];
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg     <= 6'h00;
      sync2_reg     <= 6'h00;
      lclk_last_reg <= 1'b0;
    end else begin
      sync1_reg     <= sync1_next;
      sync2_reg     <= sync2_next;
      lclk_last_reg <= lclk_last_next;
    end
  end
  logic lclk_s, fpd_n_s, opd_n_s, inv_s, dual_s, stag_n_s, rise, fall;
  assign {lclk_s, fpd_n_s, opd_n_s, inv_s, dual_s, stag_n_s} = sync2_reg;
  assign rise = lclk_s && !lclk_last_reg;
  assign fall = !lclk_s && lclk_last_reg;

  ////////////////////////////////////////////////////////////////////////
  // Edge tracker, for cover and readability of the launch moment
  edge_t edge_reg, edge_next;
  always_comb begin
    edge_next = ST_IDLE;
    if (rise) edge_next = ST_RISE;
    else if (fall) edge_next = ST_FALL;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) edge_reg <= ST_IDLE;
    else     edge_reg <= edge_next;
  end

  // A word leaves the buffer on each recovered rising link edge while it holds one
  assign pop_word = rise && buf_valid;

  ////////////////////////////////////////////////////////////////////////
  // Output registers; an empty buffer repeats the last word (underrun)
  logic [PIXEL_W-1:0] even_reg, even_next, odd_reg, odd_next, odd_hold_reg, odd_hold_next;
  logic               clk_reg, clk_next, qual_reg, qual_next, hs_reg, hs_next, vs_reg, vs_next;
  logic [2:0]         ctl_reg, ctl_next;
  logic               men_reg, men_next, a1en_reg, a1en_next;
  logic               stag_mode;
  always_comb begin
    even_next     = even_reg;
    odd_next      = odd_reg;
    odd_hold_next = odd_hold_reg;
    qual_next     = qual_reg;
    hs_next       = hs_reg;
    vs_next       = vs_reg;
    ctl_next      = ctl_reg;
    stag_mode     = dual_s && !stag_n_s;
    if (pop_word) begin
      even_next = even_field(buf_data);
      qual_next = buf_data[POS_QUAL];
      hs_next   = buf_data[POS_HS];
      vs_next   = buf_data[POS_VS];
      ctl_next  = buf_data[POS_CTL+2:POS_CTL];
      odd_hold_next = dual_s ? odd_field(buf_data) : PIXEL_ZERO;
      if (!stag_mode) odd_next = odd_hold_next;
    end
    if (fall && stag_mode) odd_next = odd_hold_reg;
    if (!dual_s) odd_next = PIXEL_ZERO;
    clk_next  = lclk_s ^ inv_s;
    men_next  = fpd_n_s && opd_n_s;
    a1en_next = fpd_n_s;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      even_reg     <= PIXEL_ZERO;
      odd_reg      <= PIXEL_ZERO;
      odd_hold_reg <= PIXEL_ZERO;
      clk_reg      <= 1'b0;
      qual_reg     <= 1'b0;
      hs_reg       <= 1'b0;
      vs_reg       <= 1'b0;
      ctl_reg      <= 3'h0;
      men_reg      <= 1'b0;
      a1en_reg     <= 1'b0;
    end else begin
      even_reg     <= even_next;
      odd_reg      <= odd_next;
      odd_hold_reg <= odd_hold_next;
      clk_reg      <= clk_next;
      qual_reg     <= qual_next;
      hs_reg       <= hs_next;
      vs_reg       <= vs_next;
      ctl_reg      <= ctl_next;
      men_reg      <= men_next;
      a1en_reg     <= a1en_next;
    end
  end

  // Logical levels always present; enables tell the pad when to drive
  assign even_pixel_out    = even_reg;
  assign odd_pixel_out     = odd_reg;
  assign pixel_out_clock   = clk_reg;
  assign active_video_flag = qual_reg;
  assign hsync_out         = hs_reg;
  assign vsync_out         = vs_reg;
  assign aux_control_out_1 = ctl_reg[0];
  assign aux_control_out_2 = ctl_reg[1];
  assign aux_control_out_3 = ctl_reg[2];
  assign main_out_en       = men_reg;
  assign aux1_out_en       = a1en_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_even_load: assert property (pop_word |=> even_reg == even_field($past(buf_data)))
    else $error("even bus not loaded from popped word");
  chk_odd_dual: assert property (pop_word && dual_s && !stag_mode ##1 dual_s |->
                                 odd_reg == odd_field($past(buf_data)))
    else $error("odd bus missing second pixel");
  chk_odd_zero: assert property (!dual_s ##1 !dual_s |-> odd_reg == PIXEL_ZERO)
    else $error("odd bus not low in single mode");
  chk_even_stable: assert property (!pop_word |=> $stable(even_reg))
    else $error("even bus moved without a clock edge");
  chk_main_en: assert property (##1 main_out_en == ($past(fpd_n_s) && $past(opd_n_s)))
    else $error("main enable wrong for power-down");
  chk_aux1_en: assert property (##1 aux1_out_en == $past(fpd_n_s))
    else $error("first control enable wrong");
  chk_clk_pol: assert property (##1 pixel_out_clock == ($past(lclk_s) ^ $past(inv_s)))
    else $error("pixel clock polarity wrong");
  chk_qual_align: assert property ($changed(qual_reg) |-> $past(pop_word))
    else $error("qualifier moved off a data edge");
  chk_qual_value: assert property (pop_word |=> qual_reg == $past(buf_data[POS_QUAL]))
    else $error("qualifier not taken from word");
  chk_stag_hold: assert property (pop_word && stag_mode ##1 dual_s |-> $stable(odd_reg))
    else $error("staggered odd bus updated on rising edge");

  cov_dual_pop:  cover property (pop_word && dual_s && !stag_mode);
  cov_stag_fall: cover property (fall && stag_mode);
  cov_outoff_only: cover property (fpd_n_s && !opd_n_s);
  cov_inverted:  cover property (inv_s && rise);
  cov_rise_seen: cover property (edge_reg == ST_RISE);
endmodule : pix_out_stage
`default_nettype wire

// file: tb/pix_sink_model.sv
// Display-side sink: samples the output pins half a pixel clock after each change.
// Assumes floated pads read low through their pull-downs.
`timescale 1ns/10ps
`default_nettype none
module pix_sink_model
  import pix_out_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 polarity,
  input  wire logic [2*PIXEL_W-1:0] pixels,
  input  wire logic                 pix_clock,
  input  wire logic [5:0]           flags,
  input  wire logic                 main_en,
  input  wire logic                 aux1_en,
  output logic                      smp_stb,
  output logic [WORD_W+PIXEL_W-1:0] smp_data
);
  logic [WORD_W-1:0]  seen;
  logic [PIXEL_W-1:0] early_q;
  logic               base, base_q, rise_q, fall_q;
  ////////////////////////////////////////////////////////////
  // Released pads are seen as zero
  assign seen = {flags[5:4] & {2{main_en}}, flags[3] & aux1_en,
                 {flags[2:0], pixels} & {(WORD_W-3){main_en}}};
  // Active edge lies half a cycle after the data change
  assign base = (pix_clock & main_en) ^ polarity;
  // Sampling two cycles after the edge keeps clear of the update
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {base_q, rise_q, fall_q, smp_stb} <= 4'h0;
      smp_data <= '0;
      early_q  <= '0;
    end else begin
      base_q   <= base;
      rise_q   <= base & !base_q;
      fall_q   <= !base & base_q;
      smp_stb  <= fall_q;
      smp_data <= {early_q, seen};
      if (rise_q) begin
        early_q <= seen[POS_QUAL-1:POS_ODD];
      end
    end
  end
endmodule : pix_sink_model
`default_nettype wire

// file: tb/testbench.sv
// Bench for the pixel output stage: random words in every mode, then power-down.
// Assumes the sink model stands on the output pins.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pix_out_pkg::*;
  localparam int XW = WORD_W + PIXEL_W;
  logic                 sys_clk, rst, link_clock, src_valid, src_ready, go, pclk, main_en, aux1_en, stb;
  logic [WORD_W-1:0]    src_word;
  logic [4:0]           pins;
  wire  [2*PIXEL_W-1:0] pixels;
  wire  [5:0]           flags;
  logic [PIXEL_W-1:0]   last_odd;
  logic [XW-1:0]        smp_data;
  logic [XW-1:0]        exp_q[$];
  int                   errors, compares, left, i, k, junk;
  ////////////////////////////////////////////////////////////
  pix_out_stage pix_out_stage_i (.sys_clk, .rst, .link_clock, .src_valid, .src_ready,
    .src_even_pixel(src_word[PIXEL_W-1:0]), .src_odd_pixel(src_word[POS_QUAL-1:POS_ODD]),
    .src_active(src_word[POS_QUAL]), .src_hsync(src_word[POS_HS]), .src_vsync(src_word[POS_VS]),
    .src_control(src_word[WORD_W-1:POS_CTL]), .full_power_down_n(pins[4]), .output_power_down_n(pins[3]),
    .clock_polarity_select(pins[2]), .pixels_per_clock_select(pins[1]), .staggered_output_select_n(pins[0]),
    .even_pixel_out(pixels[PIXEL_W-1:0]), .odd_pixel_out(pixels[2*PIXEL_W-1:PIXEL_W]), .pixel_out_clock(pclk),
    .active_video_flag(flags[0]), .hsync_out(flags[1]), .vsync_out(flags[2]), .aux_control_out_1(flags[3]),
    .aux_control_out_2(flags[4]), .aux_control_out_3(flags[5]), .main_out_en(main_en), .aux1_out_en(aux1_en));
  pix_sink_model pix_sink_model_i (.sys_clk, .rst, .polarity(pins[2]), .pixels, .pix_clock(pclk), .flags,
    .main_en, .aux1_en, .smp_stb(stb), .smp_data);
  ////////////////////////////////////////////////////////////
  // Clocks; the link only rises while a word waits, so no underrun
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = !sys_clk;
  end
  initial begin
    link_clock = 1'b0;
    // Odd offset keeps link edges off every system clock edge
    #3.3;
    forever begin
      #62.5;
      if (link_clock) begin
        link_clock = 1'b0;
      end else if (go && left > 0) begin
        link_clock = 1'b1;
        left--;
      end
    end
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    results();
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [XW-1:0] g, input logic [XW-1:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic results();
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // Pins pass two synchronisers, so settle before looking
  task automatic set_pins(input logic [4:0] p);
    pins <= p;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(XW'(main_en), XW'(p[4] & p[3]));
    chk(XW'(aux1_en), XW'(p[4]));
    chk(XW'(pclk), XW'(p[2]));
    @(posedge sys_clk);
  endtask : set_pins
  // Hold the word until taken, then note what the sink should see
  task automatic push(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] e;
    src_valid <= 1'b1;
    src_word  <= w;
    do @(negedge sys_clk); while (src_ready !== 1'b1);
    @(posedge sys_clk);
    left++;
    e = w;
    if (!pins[1]) e[POS_QUAL-1:POS_ODD] = PIXEL_ZERO;
    exp_q.push_back({(pins[1] && !pins[0]) ? last_odd : e[POS_QUAL-1:POS_ODD], e});
    last_odd = e[POS_QUAL-1:POS_ODD];
  endtask : push
  // Fill with the link stalled, check the refusal, then drain
  task automatic burst();
    go = 1'b0;
    for (k = 0; k < 6; k++) begin
      if (k == 2) begin
        @(negedge sys_clk);
        chk(XW'(src_ready), '0);
        @(posedge sys_clk);
        go = 1'b1;
      end
      push(WORD_W'({$urandom(), $urandom()}));
    end
    src_valid <= 1'b0;
    for (k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge sys_clk);
    // Words still owed after the limit count as a mismatch
    chk(XW'(exp_q.size()), '0);
    go = 1'b0;
  endtask : burst
  // Sink results against the oldest note
  always @(posedge sys_clk) begin
    if (stb === 1'b1 && exp_q.size() > 0) begin
      chk(smp_data, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    junk = $urandom(19);
    {rst, src_valid, go, src_word, left, errors, compares} = '0;
    rst = 1'b1;
    pins = 5'h18;
    last_odd = PIXEL_ZERO;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (i = 0; i < 8; i++) begin
      set_pins({2'h3, i[2:0]});
      burst();
    end
    for (i = 0; i < 4; i++) begin
      set_pins({i[1:0], 3'h0});
    end
    results();
  end
endmodule : testbench
`default_nettype wire
